// ==== hdl/adsel_defs.svh ====
// Constants of the adaptive setting selector
`ifndef ADSEL_DEFS_SVH
`define ADSEL_DEFS_SVH
// ==========================================================
// Sizes
`define ADSEL_NUM_ALT 4
`define ADSEL_PICKUP_W 16
`define ADSEL_CURVE_W 4
`define ADSEL_DIAL_W 12
`define ADSEL_RMODE_W 2
// ==========================================================
// Register offsets (word addresses on the plain port)
`define ADSEL_ADDR_W 6
`define ADSEL_OFS_ASSIGN 6'h00
`define ADSEL_OFS_STATUS 6'h01
`define ADSEL_OFS_SET_BASE 6'h08
`define ADSEL_SET_STRIDE 6'h04
`define ADSEL_FLD_PICKUP 2'h0
`define ADSEL_FLD_CURVE 2'h1
`define ADSEL_FLD_DIAL 2'h2
`define ADSEL_FLD_RMODE 2'h3
// ==========================================================
// Reset values
`define ADSEL_ASSIGN_RST 4'h0
`define ADSEL_PICKUP_RST 16'h0000
`define ADSEL_CURVE_RST 4'h0
`define ADSEL_DIAL_RST 12'h000
`define ADSEL_RMODE_RST 2'h0
`endif

// ==== hdl/adsel_pkg.sv ====
// Types of the adaptive setting selector
package adsel_pkg;
  // Which setting set is applied to the element
  typedef enum logic [2:0] {
    ADSEL_DEFAULT,
    ADSEL_ALT1,
    ADSEL_ALT2,
    ADSEL_ALT3,
    ADSEL_ALT4
  } adsel_sel_t;
endpackage

// ==== hdl/adsel_prio.sv ====
// Fixed-priority chooser of the active alternative set
`timescale 1ns/100ps
`default_nettype none
module adsel_prio
  import adsel_pkg::*;
#(
  parameter int NUM_ALT = 4
)
(
  // Qualified requests, bit 0 is set 1
  input wire logic [NUM_ALT-1:0] req_i,
  // Winner, one-hot, and whether any request is set
  output logic [NUM_ALT-1:0] grant_o,
  output logic any_o
);
  // ========================================================
  // Lowest bit wins
  always_comb
  begin
    grant_o = '0;
    any_o = 1'b0;
    for (int i = NUM_ALT - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        grant_o = '0;
        grant_o[i] = 1'b1;
        any_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/adsel_top.sv ====
// Adaptive setting selector for one protection element
//
// Contract
// - Four alternative sets besides default; at most one applied at once.
// - Several active activations: lowest-numbered set wins.
// - Alternative set applies only if assigned and while its signal is true.
// - Activation falling back returns to default values automatically.
// - No set assigned: element always uses default settings; under reset the outputs clear to zero instead.
// - Each set holds pickup, curve, dial, reset mode; switched together.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "adsel_defs.svh"
module adsel_top
  import adsel_pkg::*;
#(
  parameter int NUM_ALT = `ADSEL_NUM_ALT,
  parameter int PICKUP_W = `ADSEL_PICKUP_W,
  parameter int CURVE_W = `ADSEL_CURVE_W,
  parameter int DIAL_W = `ADSEL_DIAL_W,
  parameter int RMODE_W = `ADSEL_RMODE_W
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [`ADSEL_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Activation signals from logic functions, bit 0 is set 1
  input wire logic [NUM_ALT-1:0] act_i,
  // Default settings of the element
  input wire logic [PICKUP_W-1:0] def_pickup_i,
  input wire logic [CURVE_W-1:0] def_curve_i,
  input wire logic [DIAL_W-1:0] def_dial_i,
  input wire logic [RMODE_W-1:0] def_rmode_i,
  // Settings in force, to the element datapath
  output logic [PICKUP_W-1:0] pickup_o,
  output logic [CURVE_W-1:0] curve_o,
  output logic [DIAL_W-1:0] dial_o,
  output logic [RMODE_W-1:0] rmode_o,
  output adsel_sel_t sel_o
);
  // ========================================================
  // Elaboration checks
  initial
  begin
    if (NUM_ALT != 4)
      $error("adsel_top: NUM_ALT must be 4");
    if (PICKUP_W > 32 || DIAL_W > 32 || CURVE_W > 32 || RMODE_W > 32)
      $error("adsel_top: field wider than data bus");
  end

  // Decode an alternative-set field address; returns set index or -1
  function automatic int set_of(input logic [`ADSEL_ADDR_W-1:0] a);
    int off;
    off = int'(a) - int'(`ADSEL_OFS_SET_BASE);
    if (off >= 0 && off < NUM_ALT * int'(`ADSEL_SET_STRIDE))
      return off / int'(`ADSEL_SET_STRIDE);
    return -1;
  endfunction

  // ========================================================
  // Setting store and assignment register
  logic [NUM_ALT-1:0] assign_reg, assign_next;
  logic [PICKUP_W-1:0] pk_reg [NUM_ALT];
  logic [PICKUP_W-1:0] pk_next [NUM_ALT];
  logic [CURVE_W-1:0] cv_reg [NUM_ALT];
  logic [CURVE_W-1:0] cv_next [NUM_ALT];
  logic [DIAL_W-1:0] dl_reg [NUM_ALT];
  logic [DIAL_W-1:0] dl_next [NUM_ALT];
  logic [RMODE_W-1:0] rm_reg [NUM_ALT];
  logic [RMODE_W-1:0] rm_next [NUM_ALT];
  logic [31:0] rdata_reg, rdata_next;
  int ws;
  int rs;

  // Software writes the assignment bits and the per-set values
  always_comb
  begin
    assign_next = assign_reg;
    pk_next = pk_reg;
    cv_next = cv_reg;
    dl_next = dl_reg;
    rm_next = rm_reg;
    ws = set_of(addr_i);
    if (wr_i)
    begin
      if (addr_i == `ADSEL_OFS_ASSIGN)
        assign_next = wdata_i[NUM_ALT-1:0];
      else if (ws >= 0)
      begin
        unique case (addr_i[1:0])
          `ADSEL_FLD_PICKUP: pk_next[ws] = wdata_i[PICKUP_W-1:0];
          `ADSEL_FLD_CURVE: cv_next[ws] = wdata_i[CURVE_W-1:0];
          `ADSEL_FLD_DIAL: dl_next[ws] = wdata_i[DIAL_W-1:0];
          `ADSEL_FLD_RMODE: rm_next[ws] = wdata_i[RMODE_W-1:0];
        endcase
      end
    end
  end

  // ========================================================
  // Selection
  logic [NUM_ALT-1:0] qual;
  logic [NUM_ALT-1:0] grant;
  logic any_grant;

  assign qual = act_i & assign_reg;

  adsel_prio #(
    .NUM_ALT(NUM_ALT)
  ) u_prio (
    .req_i(qual),
    .grant_o(grant),
    .any_o(any_grant)
  );

  adsel_sel_t sel_reg, sel_next;
  logic [PICKUP_W-1:0] pickup_reg, pickup_next;
  logic [CURVE_W-1:0] curve_reg, curve_next;
  logic [DIAL_W-1:0] dial_reg, dial_next;
  logic [RMODE_W-1:0] rmode_reg, rmode_next;

  // one-hot grant picks a single set
  always_comb
  begin
    sel_next = ADSEL_DEFAULT;
    pickup_next = def_pickup_i;
    curve_next = def_curve_i;
    dial_next = def_dial_i;
    rmode_next = def_rmode_i;
    for (int i = 0; i < NUM_ALT; i++)
    begin
      if (grant[i])
      begin
        sel_next = adsel_sel_t'(i + 1);
        pickup_next = pk_reg[i];
        curve_next = cv_reg[i];
        dial_next = dl_reg[i];
        rmode_next = rm_reg[i];
      end
    end
  end

  // ========================================================
  // Read-back: assignment, state and stored values
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    rs = set_of(addr_i);
    if (rd_i)
    begin
      if (addr_i == `ADSEL_OFS_ASSIGN)
        rdata_next[NUM_ALT-1:0] = assign_reg;
      else if (addr_i == `ADSEL_OFS_STATUS)
      begin
        rdata_next[2:0] = sel_reg;
        rdata_next[8+NUM_ALT-1:8] = qual;
        rdata_next[16] = any_grant;
      end
      else if (rs >= 0)
      begin
        unique case (addr_i[1:0])
          `ADSEL_FLD_PICKUP: rdata_next[PICKUP_W-1:0] = pk_reg[rs];
          `ADSEL_FLD_CURVE: rdata_next[CURVE_W-1:0] = cv_reg[rs];
          `ADSEL_FLD_DIAL: rdata_next[DIAL_W-1:0] = dl_reg[rs];
          `ADSEL_FLD_RMODE: rdata_next[RMODE_W-1:0] = rm_reg[rs];
        endcase
      end
    end
  end

  // ========================================================
  // Registers
  // reset into default, re-evaluated every cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      assign_reg <= `ADSEL_ASSIGN_RST;
      for (int i = 0; i < NUM_ALT; i++)
      begin
        pk_reg[i] <= `ADSEL_PICKUP_RST;
        cv_reg[i] <= `ADSEL_CURVE_RST;
        dl_reg[i] <= `ADSEL_DIAL_RST;
        rm_reg[i] <= `ADSEL_RMODE_RST;
      end
      sel_reg <= ADSEL_DEFAULT;
      // Defaults are ports, so outputs clear to zero under reset
      pickup_reg <= '0;
      curve_reg <= '0;
      dial_reg <= '0;
      rmode_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      assign_reg <= assign_next;
      pk_reg <= pk_next;
      cv_reg <= cv_next;
      dl_reg <= dl_next;
      rm_reg <= rm_next;
      sel_reg <= sel_next;
      pickup_reg <= pickup_next;
      curve_reg <= curve_next;
      dial_reg <= dial_next;
      rmode_reg <= rmode_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign sel_o = sel_reg;
  assign pickup_o = pickup_reg;
  assign curve_o = curve_reg;
  assign dial_o = dial_reg;
  assign rmode_o = rmode_reg;
endmodule
`default_nettype wire

// ==== test/adsel_checker.sv ====
// Port assertions of the adaptive setting selector
`timescale 1ns/100ps
`default_nettype none
module adsel_checker
  import adsel_pkg::*;
#(
  parameter int NUM_ALT = 4,
  parameter int PICKUP_W = 16
)
(
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Selection
  input wire logic [NUM_ALT-1:0] act_i,
  input wire logic [PICKUP_W-1:0] def_pickup_i,
  input wire logic [PICKUP_W-1:0] pickup_o,
  input wire adsel_sel_t sel_o
);
  // ==========================================
  // Selection and read-data checks, all on the one clock
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Applied set still active and no assignment write in flight
  sequence s_held;
    sel_o != ADSEL_DEFAULT && act_i[sel_o - 1] && !$past(wr_i);
  endsequence
  a_sel_legal: assert property (sel_o <= ADSEL_ALT4)
    else $error("selection out of range");
  a_prio_hold: assert property (s_held |=>
    sel_o != ADSEL_DEFAULT && sel_o <= $past(sel_o))
    else $error("active set lost to a lower priority");
  a_needs_act: assert property (sel_o != ADSEL_DEFAULT |->
    (($past(act_i) >> (sel_o - 1)) & 1) != 0)
    else $error("set applied without activation");
  a_drop_default: assert property ($past(act_i) == 0 |->
    sel_o == ADSEL_DEFAULT)
    else $error("no fallback to default");
  a_default_vals: assert property (sel_o == ADSEL_DEFAULT
    && $past(reset_n_i) |-> pickup_o == $past(def_pickup_i))
    else $error("default pickup not passed");
  a_reset_default: assert property (!$past(reset_n_i) |=>
    sel_o == ADSEL_DEFAULT)
    else $error("not default after reset");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 0)
    else $error("read data without read");
endmodule
bind adsel_top adsel_checker #(.NUM_ALT(NUM_ALT), .PICKUP_W(PICKUP_W))
  adsel_checker_i (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .act_i(act_i),
  .def_pickup_i(def_pickup_i), .pickup_o(pickup_o), .sel_o(sel_o));
`default_nettype wire

// ==== test/test_adaptive_setting_selector.sv ====
// Self-checking bench of the adaptive setting selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
  cmp_count++; \
  if ((s) !== (e)) \
  begin \
    $display("BAD %s exp %h got %h", n, e, s); \
    miscompares++; \
  end
module test_adaptive_setting_selector;
  // ==========================================
  // Stimulus, outputs and model state
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, e_rd = 32'h0, asg = 32'h0;
  logic [3:0] act = 4'h0, curve, dcurve = 4'h0;
  logic [15:0] pickup, dpick = 16'h0;
  logic [11:0] dial, ddial = 12'h000;
  logic [1:0] rmode, drm = 2'h0;
  logic [2:0] sel;
  logic [36:0] e_out = 37'h0;
  logic [31:0] sv [4][4] = '{default: 32'h0};
  logic [31:0] fmask [4] = '{32'hffff, 32'hf, 32'hfff, 32'h3};
  integer seed = 32'hf740;
  int miscompares = 0;
  int cmp_count = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  adsel_top adsel_top_i (.sys_clk_i(clk), .reset_n_i(reset_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .act_i(act), .def_pickup_i(dpick),
    .def_curve_i(dcurve), .def_dial_i(ddial), .def_rmode_i(drm),
    .pickup_o(pickup), .curve_o(curve), .dial_o(dial),
    .rmode_o(rmode), .sel_o(sel));
  // Drive one cycle, check the one before, then advance the model
  task automatic cyc(logic [3:0] a, logic w, logic r, logic [5:0] ad,
    logic [31:0] wd);
    logic [31:0] d;
    int k;
    int j;
    logic [2:0] es;
    d = $random(seed);
    @(posedge clk);
    act <= a;
    wr <= w;
    rd <= r;
    addr <= ad;
    wdata <= wd;
    {dpick, dcurve, ddial, drm} <= {d, d[5:4]};
    @(negedge clk);
    `CHK("outputs", e_out, {sel, pickup, curve, dial, rmode})
    `CHK("rdata", e_rd, rdata)
    // Set shown in status is the one registered before this cycle
    es = e_out[36:34];
    k = 4;
    for (j = 3; j >= 0; j--)
      if (a[j] && asg[j])
        k = j;
    e_out = {3'h0, dpick, dcurve, ddial, drm};
    if (k < 4)
      e_out = {k[2:0] + 3'h1, sv[k][0][15:0], sv[k][1][3:0],
        sv[k][2][11:0], sv[k][3][1:0]};
    j = int'(ad) - 8;
    // Status: applied set, qualified activations of now, any alternative
    e_rd = !r ? 32'h0 : ad == 6'h00 ? asg :
      ad == 6'h01 ? {15'h0, (k < 4), 4'h0, a & asg[3:0], 5'h0, es} :
      (j >= 0 && j < 16) ? sv[j / 4][j % 4] : 32'h0;
    // Assignment changes only after this cycle's selection
    if (w && ad == 6'h00)
      asg = {28'h0, wd[3:0]};
    if (w && j >= 0 && j < 16)
      sv[j / 4][j % 4] = wd & fmask[j % 4];
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic [5:0] ad;
    int i;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // Nothing assigned: read resets, fill sets, read back
    for (i = 0; i < 48; i++)
    begin
      r = $random(seed);
      cyc(r[3:0], i >= 16 && i < 32, i < 16 || i >= 32,
        6'h08 + {2'h0, i[3:0]}, r);
    end
    // Unmapped and read-only places leave state alone
    cyc(4'h0, 1'b1, 1'b0, 6'h20, 32'hffffffff);
    cyc(4'h0, 1'b0, 1'b1, 6'h20, 32'h0);
    cyc(4'h0, 1'b1, 1'b0, 6'h01, 32'hf);
    cyc(4'h0, 1'b0, 1'b1, 6'h00, 32'h0);
    cyc(4'h0, 1'b0, 1'b1, 6'h01, 32'h0);
    // Random activations, assignments, set rewrites and reads
    for (i = 0; i < 3000; i++)
    begin
      r = $random(seed);
      ad = r[31:29] == 3'h1 ? 6'h08 + {2'h0, r[11:8]} :
        r[31:29] == 3'h2 ? r[13:8] : r[31:29] == 3'h3 ? 6'h01 : 6'h00;
      cyc(r[3:0], r[31:30] == 2'h0, r[31:30] == 2'h1,
        ad, {r[27:12], r[27:12]});
    end
    cyc(4'h0, 1'b0, 1'b0, 6'h00, 32'h0);
    // Mid-run reset: outputs clear at once, assignment and sets too
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    `CHK("reset", 69'h0, {rdata, sel, pickup, curve, dial, rmode})
    @(posedge clk);
    reset_n <= 1'b1;
    asg = 32'h0;
    sv = '{default: 32'h0};
    cyc(4'hf, 1'b0, 1'b1, 6'h00, 32'h0);
    cyc(4'hf, 1'b0, 1'b1, 6'h08, 32'h0);
    cyc(4'h0, 1'b0, 1'b0, 6'h00, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
